// ===== rtl/cct_pkg.sv
// Purpose: shared constants of the 16-bit capture/compare timer
// Assumes: byte-wide register port, one clock
// Notes: offsets are register indexes on a 4-bit address
package cct_pkg;
    // ******
    // register indexes
    // ******
    localparam logic [3:0] ADDR_CTRL1 = 4'h0;
    localparam logic [3:0] ADDR_CTRL2 = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_CAP1H = 4'h3;
    localparam logic [3:0] ADDR_CAP1L = 4'h4;
    localparam logic [3:0] ADDR_CMP1H = 4'h5;
    localparam logic [3:0] ADDR_CMP1L = 4'h6;
    localparam logic [3:0] ADDR_CAP2H = 4'h7;
    localparam logic [3:0] ADDR_CAP2L = 4'h8;
    localparam logic [3:0] ADDR_CMP2H = 4'h9;
    localparam logic [3:0] ADDR_CMP2L = 4'hA;
    localparam logic [3:0] ADDR_CNTH = 4'hB;
    localparam logic [3:0] ADDR_CNTL = 4'hC;
    localparam logic [3:0] ADDR_ACNTH = 4'hD;
    localparam logic [3:0] ADDR_ACNTL = 4'hE;
    // ******
    // first control register bits
    // ******
    localparam int C1_CAP_IE = 7;
    localparam int C1_CMP_IE = 6;
    localparam int C1_OVF_IE = 5;
    localparam int C1_LVL2 = 2;
    localparam int C1_EDGE1 = 1;
    localparam int C1_LVL1 = 0;
    // ******
    // second control register bits
    // ******
    localparam int C2_PINEN1 = 7;
    localparam int C2_PINEN2 = 6;
    localparam int C2_SPULSE = 5;
    localparam int C2_PWM = 4;
    localparam int C2_CSEL_HI = 3;
    localparam int C2_CSEL_LO = 2;
    localparam int C2_EDGE2 = 1;
    localparam int C2_EXTEDGE = 0;
    // ******
    // status register bits
    // ******
    localparam int ST_CAPF1 = 7;
    localparam int ST_CMPF1 = 6;
    localparam int ST_OVF = 5;
    localparam int ST_CAPF2 = 4;
    localparam int ST_CMPF2 = 3;
    // ******
    // values and clock selection
    // ******
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] CNT_RELOAD = 16'hFFFC;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CMP_RESET = 16'h8000;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    typedef enum logic [1:0] {
        CCT_DIV4 = 2'b00,
        CCT_DIV2 = 2'b01,
        CCT_DIV8 = 2'b10,
        CCT_EXT = 2'b11
    } cct_csel_t;
    localparam logic [2:0] PRE_END2 = 3'h1;
    localparam logic [2:0] PRE_END4 = 3'h3;
    localparam logic [2:0] PRE_END8 = 3'h7;
endpackage

// ===== rtl/cct_cap_if.sv
// Purpose: signals between timer core and one capture channel
// Assumes: single clock domain
// Notes: core drives pin, edge, count and read strobes
`timescale 1ns/1ps
interface cct_cap_if;
    logic pinLevel;
    logic edgeSel;
    logic allow;
    logic [15:0] count;
    logic rdHigh;
    logic rdLow;
    logic [15:0] value;
    logic evt;
    modport core (output pinLevel, edgeSel, allow, count, rdHigh, rdLow, input value, evt);
    modport chan (input pinLevel, edgeSel, allow, count, rdHigh, rdLow, output value, evt);
endinterface

// ===== rtl/cct_capture.sv
// Purpose: one input capture channel
// Assumes: pin synchronous to core_clk
// Notes: evt pulses one cycle per active edge
`timescale 1ns/1ps
module cct_capture (
    input wire logic core_clk, // core clock
    input wire logic sys_rst, // sync reset, high
    cct_cap_if.chan cap // link to the core
);
    logic pinPrev_reg;
    logic hold_reg;
    logic [15:0] value_reg;
    // ******
    // edge detection
    // ******
    // edge polarity picked per channel
    wire rise = cap.pinLevel & ~pinPrev_reg;
    wire fall = ~cap.pinLevel & pinPrev_reg;
    wire hit = cap.allow & (cap.edgeSel ? rise : fall);
    assign cap.evt = hit;
    assign cap.value = value_reg;
    // ******
    // transfer and read hold-off
    // ******
    // high read freezes the value until low read
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pinPrev_reg <= cap.pinLevel; // no false edge after reset
            hold_reg <= 1'b0;
            value_reg <= cct_pkg::CNT_RESET;
        end else begin
            pinPrev_reg <= cap.pinLevel;
            if (cap.rdHigh) begin
                hold_reg <= 1'b1;
            end else if (cap.rdLow) begin
                hold_reg <= 1'b0;
            end
            if (hit && !hold_reg) begin
                value_reg <= cap.count;
            end
        end
    end
endmodule // cct_capture

// ===== rtl/cct_timer16.sv
// Purpose: 16-bit free-running timer, two captures, two compares
// Assumes: byte register port, read data one cycle after strobe
// Notes: forced compare and pulse waveforms are not built here
// Operation
// - high byte read buffers low byte until read
// - lone low byte read returns live count
// - wrap to zero sets overflow flag
// - overflow request needs enable and clear mask
// - overflow flag cleared by status then low access
// - alternate low byte never clears overflow
// - runs in wait, freezes in halt
// - both select bits choose external pin edge
// - external pin synced on falling clock edge
// - active edge copies count, sets capture flag
// - per-channel capture edge select bits
// - shared capture enable gates capture request
// - capture flag cleared by status then low access
// - high read holds capture until low read
// - pulse modes disable capture channel one
// - capture pins always connected to timer
// - compare registers software only, reset 8000h
// - match sets flag and drives enabled pin
// - compare request; flag cleared two-step or by a low write alone
// - high write inhibits compare until low write
// - divide-by-2 matches count, others count plus one
// - disabled pin stays port, request still possible
// - internal clock divided by 2, 4 or 8
// - counter low write reloads FFFCh
// - alternate pair reads same count, low write also reloads
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
module cct_timer16 (
    input wire logic core_clk, // 40 MHz core clock
    input wire logic sys_rst, // sync reset, high
    input wire logic [3:0] regAddr, // register index
    input wire logic [7:0] regWdata, // write data
    input wire logic regWr, // write strobe
    input wire logic regRd, // read strobe
    output logic [7:0] regRdata, // read data, next cycle
    input wire logic cpuIntMask, // cpu global mask, high masks
    input wire logic haltMode, // cpu halt state
    input wire logic extClkPin, // external count clock
    input wire logic [1:0] capPin, // capture inputs
    output logic [1:0] cmpPin, // compare pin levels
    output logic [1:0] cmpPinOwned, // timer owns compare pin
    output logic timerIrq // timer interrupt request
);
    logic [7:0] ctrl1_reg;
    logic [7:0] ctrl2_reg;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic [2:0] pre_reg;
    logic [7:0] lowBuf_reg;
    logic lowBufValid_reg;
    logic extMeta_reg;
    logic extSync_reg;
    logic extPrev_reg;
    logic ovf_reg;
    logic ovfArm_reg;
    logic [1:0] capFlag_reg;
    logic [1:0] capArm_reg;
    logic [1:0] cmpFlag_reg;
    logic [1:0] cmpArm_reg;
    logic [1:0] cmpLatch_reg;
    logic [1:0] cmpInhibit_reg;
    logic [1:0] matchPrev_reg;
    logic [15:0] cmpVal_reg [2];
    logic [7:0] rdata_next;
    logic [7:0] rdMux;
    logic [1:0] capEvt;
    logic [1:0] matchNow;
    logic [15:0] capVal [2];
    // ******
    // register decode
    // ******
    // one wire per access kind keeps the flops short
    wire wrCtrl1 = regWr && regAddr == cct_pkg::ADDR_CTRL1;
    wire wrCtrl2 = regWr && regAddr == cct_pkg::ADDR_CTRL2;
    wire rdStatus = regRd && regAddr == cct_pkg::ADDR_STATUS;
    wire rdCntH = regRd && (regAddr == cct_pkg::ADDR_CNTH || regAddr == cct_pkg::ADDR_ACNTH);
    wire rdCntL = regRd && (regAddr == cct_pkg::ADDR_CNTL || regAddr == cct_pkg::ADDR_ACNTL);
    wire wrCntL = regWr && (regAddr == cct_pkg::ADDR_CNTL || regAddr == cct_pkg::ADDR_ACNTL);
    wire accCntL = (regRd || regWr) && regAddr == cct_pkg::ADDR_CNTL;
    wire [1:0] accCapL = {(regRd || regWr) && regAddr == cct_pkg::ADDR_CAP2L,
                          (regRd || regWr) && regAddr == cct_pkg::ADDR_CAP1L};
    wire [1:0] rdCapH = {regRd && regAddr == cct_pkg::ADDR_CAP2H,
                         regRd && regAddr == cct_pkg::ADDR_CAP1H};
    wire [1:0] rdCapL = {regRd && regAddr == cct_pkg::ADDR_CAP2L,
                         regRd && regAddr == cct_pkg::ADDR_CAP1L};
    wire [1:0] wrCmpH = {regWr && regAddr == cct_pkg::ADDR_CMP2H,
                         regWr && regAddr == cct_pkg::ADDR_CMP1H};
    wire [1:0] wrCmpL = {regWr && regAddr == cct_pkg::ADDR_CMP2L,
                         regWr && regAddr == cct_pkg::ADDR_CMP1L};
    wire [1:0] accCmpL = {(regRd || regWr) && regAddr == cct_pkg::ADDR_CMP2L,
                          (regRd || regWr) && regAddr == cct_pkg::ADDR_CMP1L};
    // ******
    // mode decode
    // ******
    wire [1:0] csel = {ctrl2_reg[cct_pkg::C2_CSEL_HI], ctrl2_reg[cct_pkg::C2_CSEL_LO]};
    wire pulseMode = ctrl2_reg[cct_pkg::C2_SPULSE] | ctrl2_reg[cct_pkg::C2_PWM];
    wire isDiv2 = csel == cct_pkg::CCT_DIV2;
    wire isExt = csel == cct_pkg::CCT_EXT;
    wire [7:0] status = {capFlag_reg[0], cmpFlag_reg[0], ovf_reg, capFlag_reg[1],
                         cmpFlag_reg[1], 3'b000};
    // ******
    // prescaler and count tick
    // ******
    // prescaler end value from the select code
    logic [2:0] preEnd;
    always_comb begin
        case (csel)
            cct_pkg::CCT_DIV2: preEnd = cct_pkg::PRE_END2;
            cct_pkg::CCT_DIV8: preEnd = cct_pkg::PRE_END8;
            default: preEnd = cct_pkg::PRE_END4;
        endcase
    end
    // active external edge; spacing of four clocks is the source's job
    wire extEdge = (extSync_reg ^ extPrev_reg) &
                   (ctrl2_reg[cct_pkg::C2_EXTEDGE] ? extSync_reg : ~extSync_reg);
    wire intTick = pre_reg == preEnd;
    // halt freezes everything that counts, wait has no effect
    wire tick = ~haltMode & (isExt ? extEdge : intTick);
    wire wrap = tick && !wrCntL && count_reg == cct_pkg::CNT_MAX;
    // ******
    // counter next value
    // ******
    // software reload beats a tick in the same cycle
    always_comb begin
        count_next = count_reg;
        if (wrCntL) begin
            count_next = cct_pkg::CNT_RELOAD;
        end else if (tick) begin
            count_next = count_reg + 16'h0001;
        end
    end
    // ******
    // external clock synchroniser
    // ******
    // first stage on the falling edge halves the settle window
    always_ff @(negedge core_clk) begin
        if (sys_rst) begin
            extMeta_reg <= 1'b0;
        end else begin
            extMeta_reg <= extClkPin;
        end
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            extSync_reg <= 1'b0;
            extPrev_reg <= 1'b0;
        end else begin
            extSync_reg <= extMeta_reg;
            extPrev_reg <= extSync_reg;
        end
    end
    // ******
    // counter and prescaler
    // ******
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            count_reg <= cct_pkg::CNT_RESET;
            pre_reg <= 3'h0;
        end else begin
            count_reg <= count_next;
            if (wrCntL || intTick) begin
                pre_reg <= 3'h0;
            end else if (!haltMode) begin
                pre_reg <= pre_reg + 3'h1;
            end
        end
    end
    // ******
    // control registers
    // ******
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl1_reg <= cct_pkg::CTRL_RESET;
            ctrl2_reg <= cct_pkg::CTRL_RESET;
        end else begin
            if (wrCtrl1) begin
                ctrl1_reg <= regWdata;
            end
            if (wrCtrl2) begin
                ctrl2_reg <= regWdata;
            end
        end
    end
    // ******
    // 16-bit count read buffer
    // ******
    // repeated high reads must not refresh the frozen low byte
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            lowBuf_reg <= 8'h00;
            lowBufValid_reg <= 1'b0;
        end else if (rdCntH && !lowBufValid_reg) begin
            lowBuf_reg <= count_reg[7:0];
            lowBufValid_reg <= 1'b1;
        end else if (rdCntL) begin
            lowBufValid_reg <= 1'b0;
        end
    end
    // ******
    // overflow flag
    // ******
    // a wrap in the clearing cycle keeps the flag set
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ovf_reg <= 1'b0;
            ovfArm_reg <= 1'b0;
        end else begin
            if (wrap) begin
                ovf_reg <= 1'b1;
            end else if (accCntL && ovfArm_reg) begin
                ovf_reg <= 1'b0;
            end
            if (rdStatus) begin
                ovfArm_reg <= ovf_reg;
            end else if (accCntL) begin
                ovfArm_reg <= 1'b0;
            end
        end
    end
    // ******
    // capture channels
    // ******
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : gCap
            cct_cap_if capBus ();
            assign capBus.pinLevel = capPin[gi];
            assign capBus.edgeSel = (gi == 0) ? ctrl1_reg[cct_pkg::C1_EDGE1]
                                              : ctrl2_reg[cct_pkg::C2_EDGE2];
            assign capBus.allow = (gi == 0) ? ~pulseMode : 1'b1;
            assign capBus.count = count_reg;
            assign capBus.rdHigh = rdCapH[gi];
            assign capBus.rdLow = rdCapL[gi];
            assign capEvt[gi] = capBus.evt;
            assign capVal[gi] = capBus.value;
            cct_capture uCap (
                .core_clk(core_clk),
                .sys_rst(sys_rst),
                .cap(capBus)
            );
            // capture flag, event wins over the clear
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    capFlag_reg[gi] <= 1'b0;
                    capArm_reg[gi] <= 1'b0;
                end else begin
                    if (capEvt[gi]) begin
                        capFlag_reg[gi] <= 1'b1;
                    end else if (accCapL[gi] && capArm_reg[gi]) begin
                        capFlag_reg[gi] <= 1'b0;
                    end
                    if (rdStatus) begin
                        capArm_reg[gi] <= capFlag_reg[gi];
                    end else if (accCapL[gi]) begin
                        capArm_reg[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate
    // ******
    // compare channels
    // ******
    generate
        for (gi = 0; gi < 2; gi++) begin : gCmp
            // slower clocks match one count later
            wire [15:0] target = isDiv2 ? cmpVal_reg[gi] : cmpVal_reg[gi] + 16'h0001;
            wire lvl = (gi == 0) ? ctrl1_reg[cct_pkg::C1_LVL1] : ctrl1_reg[cct_pkg::C1_LVL2];
            assign matchNow[gi] = ~cmpInhibit_reg[gi] && count_reg == target;
            wire hit = matchNow[gi] & ~matchPrev_reg[gi];
            assign cmpPinOwned[gi] = (gi == 0) ? ctrl2_reg[cct_pkg::C2_PINEN1]
                                               : ctrl2_reg[cct_pkg::C2_PINEN2];
            assign cmpPin[gi] = cmpLatch_reg[gi];
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    cmpVal_reg[gi] <= cct_pkg::CMP_RESET;
                    cmpInhibit_reg[gi] <= 1'b0;
                    cmpFlag_reg[gi] <= 1'b0;
                    cmpArm_reg[gi] <= 1'b0;
                    cmpLatch_reg[gi] <= 1'b0;
                    matchPrev_reg[gi] <= 1'b0;
                end else begin
                    matchPrev_reg[gi] <= matchNow[gi];
                    if (wrCmpH[gi]) begin
                        cmpVal_reg[gi][15:8] <= regWdata;
                        cmpInhibit_reg[gi] <= 1'b1;
                    end else if (wrCmpL[gi]) begin
                        cmpVal_reg[gi][7:0] <= regWdata;
                        cmpInhibit_reg[gi] <= 1'b0;
                    end
                    if (hit) begin
                        cmpFlag_reg[gi] <= 1'b1;
                    end else if (wrCmpL[gi] || (accCmpL[gi] && cmpArm_reg[gi])) begin
                        cmpFlag_reg[gi] <= 1'b0;
                    end
                    if (rdStatus) begin
                        cmpArm_reg[gi] <= cmpFlag_reg[gi];
                    end else if (accCmpL[gi]) begin
                        cmpArm_reg[gi] <= 1'b0;
                    end
                    // latch moves only on a match of an owned pin
                    if (hit && cmpPinOwned[gi]) begin
                        cmpLatch_reg[gi] <= lvl;
                    end
                end
            end
        end
    endgenerate
    // ******
    // interrupt request
    // ******
    // flags stay pending while masked
    wire capReq = ctrl1_reg[cct_pkg::C1_CAP_IE] & |capFlag_reg;
    wire cmpReq = ctrl1_reg[cct_pkg::C1_CMP_IE] & |cmpFlag_reg;
    wire ovfReq = ctrl1_reg[cct_pkg::C1_OVF_IE] & ovf_reg;
    assign timerIrq = ~cpuIntMask & (capReq | cmpReq | ovfReq);
    // ******
    // read mux
    // ******
    // unmapped indexes read as zero
    always_comb begin
        case (regAddr)
            cct_pkg::ADDR_CTRL1: rdMux = ctrl1_reg;
            cct_pkg::ADDR_CTRL2: rdMux = ctrl2_reg;
            cct_pkg::ADDR_STATUS: rdMux = status;
            cct_pkg::ADDR_CAP1H: rdMux = capVal[0][15:8];
            cct_pkg::ADDR_CAP1L: rdMux = capVal[0][7:0];
            cct_pkg::ADDR_CMP1H: rdMux = cmpVal_reg[0][15:8];
            cct_pkg::ADDR_CMP1L: rdMux = cmpVal_reg[0][7:0];
            cct_pkg::ADDR_CAP2H: rdMux = capVal[1][15:8];
            cct_pkg::ADDR_CAP2L: rdMux = capVal[1][7:0];
            cct_pkg::ADDR_CMP2H: rdMux = cmpVal_reg[1][15:8];
            cct_pkg::ADDR_CMP2L: rdMux = cmpVal_reg[1][7:0];
            cct_pkg::ADDR_CNTH, cct_pkg::ADDR_ACNTH: rdMux = count_reg[15:8];
            cct_pkg::ADDR_CNTL, cct_pkg::ADDR_ACNTL:
                rdMux = lowBufValid_reg ? lowBuf_reg : count_reg[7:0];
            default: rdMux = 8'h00;
        endcase
    end
    assign rdata_next = regRd ? rdMux : 8'h00;
    // read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            regRdata <= 8'h00;
        end else begin
            regRdata <= rdata_next;
        end
    end
endmodule // cct_timer16

// ===== tb/cct_timer16_sva.sv
// Purpose: port checker for the capture/compare timer
// Assumes: sees only the top module ports
// Notes: bound to every cct_timer16 instance
`timescale 1ns/1ps
module cct_timer16_sva (
    input wire logic core_clk, // clock
    input wire logic sys_rst, // sync reset
    input wire logic [3:0] regAddr, // index
    input wire logic [7:0] regWdata, // write data
    input wire logic regWr, // write strobe
    input wire logic regRd, // read strobe
    input wire logic [7:0] regRdata, // read data
    input wire logic cpuIntMask, // cpu mask
    input wire logic haltMode, // halt
    input wire logic [1:0] cmpPin, // pin latch
    input wire logic [1:0] cmpPinOwned, // pin owned
    input wire logic timerIrq // request
);
    // ******
    // properties
    // ******
    default clocking dcb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    logic cmpWr_reg;
    // remembers a channel 1 compare write, so the reset value is only judged before one
    always_ff @(posedge core_clk) begin
        if (sys_rst) cmpWr_reg <= 1'b0;
        else if (regWr && regAddr inside {cct_pkg::ADDR_CMP1H, cct_pkg::ADDR_CMP1L}) cmpWr_reg <= 1'b1;
    end
    property p_irqMask;
        timerIrq |-> !cpuIntMask;
    endproperty
    a_irqMask: assert property (p_irqMask) else $error("request while masked");
    property p_irqHold;
        timerIrq && !regWr && !regRd |=> timerIrq || cpuIntMask;
    endproperty
    a_irqHold: assert property (p_irqHold) else $error("request lost without access");
    property p_ownWrite;
        regWr && regAddr == cct_pkg::ADDR_CTRL2 |=> cmpPinOwned == {$past(regWdata[6]), $past(regWdata[7])};
    endproperty
    a_ownWrite: assert property (p_ownWrite) else $error("pin ownership wrong");
    property p_pinReset;
        $fell(sys_rst) |-> cmpPin == 2'b00;
    endproperty
    a_pinReset: assert property (p_pinReset) else $error("pin latch not low");
    property p_pinOwnedOnly;
        ((cmpPin ^ $past(cmpPin)) & ~$past(cmpPinOwned)) == 2'b00;
    endproperty
    a_pinOwnedOnly: assert property (p_pinOwnedOnly) else $error("unowned pin moved");
    property p_reload;
        regWr && regAddr == cct_pkg::ADDR_CNTL ##2 regRd && regAddr == cct_pkg::ADDR_CNTH |=> regRdata == 8'hFF;
    endproperty
    a_reload: assert property (p_reload) else $error("reload high byte wrong");
    property p_haltFreeze;
        regRd && regAddr == cct_pkg::ADDR_ACNTH && haltMode ##1 haltMode ##1 regRd && regAddr == cct_pkg::ADDR_ACNTH
            |=> regRdata == $past(regRdata, 2);
    endproperty
    a_haltFreeze: assert property (p_haltFreeze) else $error("count moved in halt");
    property p_cmpReset;
        regRd && regAddr == cct_pkg::ADDR_CMP1H && !cmpWr_reg |=> regRdata == 8'h80;
    endproperty
    a_cmpReset: assert property (p_cmpReset) else $error("compare reset value wrong");
endmodule // cct_timer16_sva
bind cct_timer16 cct_timer16_sva u_sva (.core_clk, .sys_rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .cpuIntMask, .haltMode, .cmpPin, .cmpPinOwned, .timerIrq);

// ===== tb/cct_pins_model.sv
// Purpose: far-side pins: external clock and capture inputs
// Assumes: changes only after rising edges
// Notes: clock stands still while not running
`timescale 1ns/1ps
module cct_pins_model (
    input wire logic core_clk, // clock
    input wire logic extRun, // run the external clock
    input wire logic [1:0] capToggle, // toggle a capture pin
    output logic extClkPin, // external clock
    output logic [1:0] capPin // capture inputs
);
    int gap;
    initial begin
        extClkPin = 1'b0;
        capPin = 2'b00;
        gap = 0;
    end
    // random half periods of 3 to 5 clocks keep like edges 6 apart at least
    always @(posedge core_clk) begin
        if (gap > 0) gap <= gap - 1;
        else if (extRun) begin
            extClkPin <= ~extClkPin;
            gap <= 2 + $urandom % 3;
        end
        capPin <= capPin ^ capToggle;
    end
endmodule // cct_pins_model

// ===== tb/capture_compare_timer16_tb_top.sv
// Purpose: self-checking bench of the timer
// Assumes: reads answered one cycle after strobe
// Notes: expected read data queued by the driver
`timescale 1ns/1ps
`define CHK(n, e, m, g) begin check_count++; if (((g) & (m)) !== ((e) & (m))) begin fails++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module capture_compare_timer16_tb_top;
    typedef struct {string n; logic [7:0] e; logic [7:0] m;} cct_exp_t;
    logic core_clk, sys_rst, regWr, regRd, cpuIntMask, haltMode, extRun, rdLag, timerIrq, extClkPin;
    logic [3:0] regAddr;
    logic [7:0] regWdata, regRdata, d;
    logic [1:0] capPin, cmpPin, cmpPinOwned, capTog;
    cct_exp_t expQ[$];
    cct_exp_t ex;
    int fails = 0;
    int check_count = 0;
    cct_timer16 u_dut (.core_clk, .sys_rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .cpuIntMask,
        .haltMode, .extClkPin, .capPin, .cmpPin, .cmpPinOwned, .timerIrq);
    cct_pins_model u_pins (.core_clk, .extRun, .capToggle(capTog), .extClkPin, .capPin);
    // ******
    // clock, bus tasks, monitor
    // ******
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m, input string n);
        @(posedge core_clk);
        regRd <= 1'b1;
        regAddr <= a;
        expQ.push_back('{n, e, m});
        @(posedge core_clk);
        regRd <= 1'b0;
    endtask
    task automatic pin(input logic [1:0] b);
        @(posedge core_clk);
        capTog <= b;
        @(posedge core_clk);
        capTog <= 2'b00;
        repeat (3) @(posedge core_clk);
    endtask
    task automatic chkIrq(input logic e);
        @(negedge core_clk);
        `CHK("irq", {7'h0, e}, 8'h01, {7'h0, timerIrq})
    endtask
    // data stands only in the cycle after the strobe, so sample mid-cycle
    always @(posedge core_clk) rdLag <= regRd;
    always @(negedge core_clk) begin
        if (rdLag === 1'b1) begin
            ex = expQ.pop_front();
            `CHK(ex.n, ex.e, ex.m, regRdata)
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // watchdog far beyond the few hundred cycles the sequence needs
    initial begin
        #100000;
        fails++;
        close_out();
    end
    // ******
    // scenarios
    // ******
    initial begin
        {regWr, regRd, haltMode, extRun, regAddr, regWdata, capTog} = '0;
        {sys_rst, cpuIntMask} = 2'b11;
        void'($urandom(32'h4bd4));
        d = 8'($urandom);
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(cct_pkg::ADDR_CMP1H, 8'h80, 8'hFF, "cmp1h");
        rd(4'hF, 8'h00, 8'hFF, "spare");
        wr(cct_pkg::ADDR_CMP2H, d);
        wr(cct_pkg::ADDR_CMP2L, ~d);
        rd(cct_pkg::ADDR_CMP2H, d, 8'hFF, "cmp2h");
        rd(cct_pkg::ADDR_CMP2L, ~d, 8'hFF, "cmp2l");
        // divide by 2, reload, wrap while the low byte stays buffered
        wr(cct_pkg::ADDR_CTRL2, 8'h04);
        wr(cct_pkg::ADDR_CNTL, d);
        rd(cct_pkg::ADDR_CNTH, 8'hFF, 8'hFF, "cnth");
        repeat (20) @(posedge core_clk);
        rd(cct_pkg::ADDR_CNTH, 8'h00, 8'hFF, "cnth2");
        rd(cct_pkg::ADDR_CNTL, 8'hFC, 8'hFC, "bufl");
        rd(cct_pkg::ADDR_CNTL, 8'h00, 8'hF0, "livel");
        wr(cct_pkg::ADDR_CTRL1, 8'h20);
        chkIrq(1'b0);
        @(posedge core_clk) cpuIntMask <= 1'b0;
        chkIrq(1'b1);
        rd(cct_pkg::ADDR_STATUS, 8'h20, 8'h20, "ovf");
        rd(cct_pkg::ADDR_ACNTL, 8'h00, 8'hE0, "altl");
        rd(cct_pkg::ADDR_STATUS, 8'h20, 8'h20, "ovfkept");
        rd(cct_pkg::ADDR_CNTL, 8'h00, 8'hE0, "clr");
        rd(cct_pkg::ADDR_STATUS, 8'h00, 8'h20, "ovfclr");
        chkIrq(1'b0);
        // divide by 8, reload, then freeze in halt
        wr(cct_pkg::ADDR_CTRL2, 8'h08);
        wr(cct_pkg::ADDR_CNTL, d);
        haltMode <= 1'b1;
        rd(cct_pkg::ADDR_ACNTH, 8'hFF, 8'hFF, "acnth");
        rd(cct_pkg::ADDR_ACNTH, 8'hFF, 8'hFF, "acnth2");
        rd(cct_pkg::ADDR_ACNTL, 8'hFC, 8'hFF, "acntl");
        wr(cct_pkg::ADDR_CTRL1, 8'h82);
        pin(2'b01);
        rd(cct_pkg::ADDR_STATUS, 8'h80, 8'h90, "capf1");
        chkIrq(1'b1);
        rd(cct_pkg::ADDR_CAP1H, 8'hFF, 8'hFF, "cap1h");
        rd(cct_pkg::ADDR_CAP1L, 8'hFC, 8'hFF, "cap1l");
        rd(cct_pkg::ADDR_STATUS, 8'h00, 8'h80, "capclr");
        pin(2'b10);
        rd(cct_pkg::ADDR_STATUS, 8'h00, 8'h10, "capf2no");
        pin(2'b10);
        rd(cct_pkg::ADDR_STATUS, 8'h10, 8'h10, "capf2");
        rd(cct_pkg::ADDR_CAP2H, 8'hFF, 8'hFF, "cap2h");
        wr(cct_pkg::ADDR_CTRL2, 8'h18);
        pin(2'b01);
        pin(2'b01);
        rd(cct_pkg::ADDR_STATUS, 8'h00, 8'h80, "pwmcap");
        haltMode <= 1'b0;
        // both channels match; only channel 1 owns its pin
        wr(cct_pkg::ADDR_CTRL2, 8'h80);
        wr(cct_pkg::ADDR_CTRL1, 8'h45);
        for (int i = 0; i < 4; i++) wr(cct_pkg::ADDR_CMP1H + 4'(i[1] * 4 + i[0]), {7'h0, i[0]} * 8'h06);
        wr(cct_pkg::ADDR_CNTL, d);
        repeat (60) @(posedge core_clk);
        `CHK("pins", 8'h01, 8'h03, {6'h0, cmpPin})
        rd(cct_pkg::ADDR_STATUS, 8'h48, 8'h48, "cmpf");
        chkIrq(1'b1);
        rd(cct_pkg::ADDR_CNTL, 8'h00, 8'hE0, "clr2");
        rd(cct_pkg::ADDR_STATUS, 8'h00, 8'h20, "ovfclr2");
        // external clock, falling edges counted
        wr(cct_pkg::ADDR_CTRL2, 8'h0C);
        extRun <= 1'b1;
        wr(cct_pkg::ADDR_CNTL, d);
        repeat (80) @(posedge core_clk);
        rd(cct_pkg::ADDR_STATUS, 8'h20, 8'h20, "extovf");
        repeat (2) @(posedge core_clk);
        close_out();
    end
endmodule // capture_compare_timer16_tb_top
